// >>> core/irsb_pkg.sv
// Shared constants of the IR sensor register bank.
// Assumes a 200 MHz core clock; no other dependency.
package irsb_pkg;
   // Register pointers
   localparam logic [7:0] PTR_OBJ   = 8'h00;
   localparam logic [7:0] PTR_DIE   = 8'h01;
   localparam logic [7:0] PTR_CFG   = 8'h02;
   localparam logic [7:0] PTR_MAKER = 8'hFE;
   localparam logic [7:0] PTR_PART  = 8'hFF;
   localparam logic [7:0] PTR_RESET = 8'h00;
   // Slave address: fixed upper bits, value before any frame
   localparam logic [3:0] ADDR_PREFIX = 4'h8;
   localparam logic [6:0] ADDR_RESET  = 7'h40;
   // Configuration field positions and reset values
   localparam int CFG_RST_BIT  = 15;
   localparam int CFG_MODE_LSB = 12;
   localparam int CFG_RATE_LSB = 9;
   localparam int CFG_EN_BIT   = 8;
   localparam int CFG_RDY_BIT  = 7;
   localparam logic [2:0] MODE_RESET = 3'h7;
   localparam logic [2:0] MODE_CONT  = 3'h7;
   localparam logic [2:0] RATE_RESET = 3'h2;
   localparam logic [2:0] RATE_MAX   = 3'h4;
   localparam logic [15:0] CFG_RESET = 16'h7400;
   // Result reset values and clip codes
   localparam logic [15:0] RES_RESET   = 16'h0000;
   localparam logic [15:0] OBJ_POS_SAT = 16'h7FFF;
   localparam logic [15:0] OBJ_NEG_SAT = 16'h8000;
   // One sample period: 250 ms at the fastest rate
   localparam int SAMPLE_PERIOD_MS = 250;
   localparam int CLK_FREQ_KHZ     = 200000;
   localparam int SAMPLE_CYC       = SAMPLE_PERIOD_MS * CLK_FREQ_KHZ;
   // Identity values, arbitrary
   localparam logic [15:0] MAKER_ID_DEF = 16'hA5C3;
   localparam logic [15:0] PART_ID_DEF  = 16'h0B17;
   // Link bit counter marks and synchroniser lanes
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK  = 4'h8;
   localparam int SY_SCL = 0;
   localparam int SY_SDA = 1;
   localparam int SY_LOW = 2;
   localparam int SY_HIGH = 3;
   localparam int SY_EV  = 4;
   localparam int SY_RD  = 5;
   localparam int SY_W   = 6;
   typedef enum logic [2:0] {
      L_ADDR, L_PTR, L_WMSB, L_WLSB, L_WIGN, L_READ, L_IDLE
   } irsb_link_state_t;
endpackage

// >>> core/irsb_if.sv
// Carrier between the link-clock shifter and the core bank.
// Toggles and words cross domains; receivers synchronise the toggles, while words are only held still.
`timescale 1ns/1ps
`default_nettype none
interface irsb_if;
   logic        ev_tgl;      // Write event toggle
   logic        ev_has_data; // Event carries a data word
   logic [7:0]  ev_ptr;
   logic [15:0] ev_data;
   logic        rd_tgl;      // Read frame toggle
   logic [15:0] rd_word;     // Frozen while link runs
   logic [6:0]  slave_addr;
   logic        link_rst_n;  // Held low between frames
   logic        core_rst_n;  // Core reset; toggles start from zero
   modport link (output ev_tgl, ev_has_data, ev_ptr, ev_data, rd_tgl,
                 input rd_word, slave_addr, link_rst_n, core_rst_n);
   modport core (input ev_tgl, ev_has_data, ev_ptr, ev_data, rd_tgl,
                 output rd_word, slave_addr, link_rst_n, core_rst_n);
endinterface
`default_nettype wire

// >>> core/irsb_link.sv
// Serial shifter of the bank, clocked by the bus clock.
// Assumes the core holds link_rst_n low outside frames.
`timescale 1ns/1ps
`default_nettype none
module irsb_link (
   // Bus pins
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      sda_o,
   output logic      sda_oe_o,
   // Core side
   irsb_if.link      lk
);
   irsb_pkg::irsb_link_state_t st_q;
   logic [3:0] bit_q;
   logic [6:0] sh_q;
   logic [7:0] hi_q;
   logic       ack_q, rd_hi_q, sent_q;
   logic [7:0] byte_w, out_w;
   assign byte_w = {sh_q, sda_i};
   assign out_w  = rd_hi_q ? lk.rd_word[15:8] : lk.rd_word[7:0];
   ////////////////////////////////////////////////////////////////////
   // Rising edge: shift in, decide at bit 8, master ack at bit 9
   always_ff @(posedge scl_i or negedge lk.link_rst_n) begin
      if (!lk.link_rst_n) begin
         st_q <= irsb_pkg::L_ADDR;
         bit_q <= 4'h0;
         sh_q <= 7'h00;
         hi_q <= 8'h00;
         ack_q <= 1'b0;
         rd_hi_q <= 1'b1;
         sent_q <= 1'b0;
      end else if (bit_q == irsb_pkg::BIT_ACK) begin
         bit_q <= 4'h0;
         if (sent_q && sda_i) st_q <= irsb_pkg::L_IDLE; // Master nack
         if (sent_q) rd_hi_q <= ~rd_hi_q;
         sent_q <= 1'b0;
      end else begin
         bit_q <= bit_q + 4'h1;
         sh_q <= byte_w[6:0];
         if (bit_q == irsb_pkg::BIT_LAST) begin
            ack_q <= (st_q != irsb_pkg::L_IDLE) &&
                     (st_q != irsb_pkg::L_READ);
            sent_q <= (st_q == irsb_pkg::L_READ);
            unique case (st_q)
               irsb_pkg::L_ADDR: begin
                  ack_q <= (byte_w[7:1] == lk.slave_addr);
                  if (byte_w[7:1] != lk.slave_addr)
                     st_q <= irsb_pkg::L_IDLE;
                  else if (byte_w[0]) st_q <= irsb_pkg::L_READ;
                  else st_q <= irsb_pkg::L_PTR;
               end
               irsb_pkg::L_PTR:  st_q <= irsb_pkg::L_WMSB;
               irsb_pkg::L_WMSB: st_q <= irsb_pkg::L_WLSB;
               irsb_pkg::L_WLSB: st_q <= irsb_pkg::L_WIGN;
               default: ;
            endcase
            if (st_q == irsb_pkg::L_WMSB) hi_q <= byte_w;
         end
      end
   end
   // Event words settle on the same edge that flips the toggle
   always_ff @(posedge scl_i or negedge lk.link_rst_n) begin
      if (!lk.link_rst_n) begin
         lk.ev_ptr <= 8'h00;
      end else if (bit_q == irsb_pkg::BIT_LAST &&
                   st_q == irsb_pkg::L_PTR) begin
         lk.ev_ptr <= byte_w;
      end
   end
   // Toggles survive link resets so the core never misses one;
   // only the core reset, taken while the bus idles, clears them
   always_ff @(posedge scl_i or negedge lk.core_rst_n) begin
      if (!lk.core_rst_n) begin
         lk.ev_tgl <= 1'b0;
         lk.ev_has_data <= 1'b0;
         lk.ev_data <= 16'h0000;
         lk.rd_tgl <= 1'b0;
      end else if (bit_q == irsb_pkg::BIT_LAST && lk.link_rst_n) begin
         if (st_q == irsb_pkg::L_PTR || st_q == irsb_pkg::L_WLSB)
            lk.ev_tgl <= ~lk.ev_tgl;
         lk.ev_has_data <= (st_q == irsb_pkg::L_WLSB);
         if (st_q == irsb_pkg::L_WLSB) lk.ev_data <= {hi_q, byte_w};
         if (st_q == irsb_pkg::L_ADDR && byte_w[0] &&
             byte_w[7:1] == lk.slave_addr)
            lk.rd_tgl <= ~lk.rd_tgl;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Falling edge: pull low for ack or for a zero data bit
   always_ff @(negedge scl_i or negedge lk.link_rst_n) begin
      if (!lk.link_rst_n) begin
         sda_oe_o <= 1'b0;
         sda_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
         if (bit_q == irsb_pkg::BIT_ACK) sda_oe_o <= ack_q;
         else sda_oe_o <= (st_q == irsb_pkg::L_READ) &&
                          !out_w[3'(irsb_pkg::BIT_LAST - bit_q)];
      end
   end
endmodule
`default_nettype wire

// >>> core/irsb_conv.sv
// Conversion pacing, averaging and result clipping.
// Samples come from same-clock front-end logic.
`timescale 1ns/1ps
`default_nettype none
module irsb_conv #(
   parameter int OBJ_W      = 18,
   parameter int SAMPLE_CYC = irsb_pkg::SAMPLE_CYC
) (
   input  wire logic              clk_i,
   input  wire logic              rst_ni,
   input  wire logic              ce_i,
   input  wire logic              soft_rst_i,
   input  wire logic              run_i,
   input  wire logic [2:0]        rate_i,
   input  wire logic [OBJ_W-1:0]  obj_i,
   input  wire logic [13:0]       die_i,
   output logic                   done_o,
   output logic [15:0]            obj_o,
   output logic [13:0]            die_o
);
   logic [31:0]        tick_q;
   logic [3:0]         n_q;
   logic signed [OBJ_W+3:0] oacc_q, osum, oavg;
   logic signed [17:0] dacc_q, dsum, davg;
   logic [2:0]         rate;
   assign rate = (rate_i > irsb_pkg::RATE_MAX) ? irsb_pkg::RATE_MAX : rate_i;
   assign osum = oacc_q + (OBJ_W+4)'(signed'(obj_i));
   assign dsum = dacc_q + 18'(signed'(die_i));
   assign oavg = osum >>> rate;
   assign davg = dsum >>> rate;
   // Stopping clears the run at once, so a partial average is lost
   always_ff @(posedge clk_i or negedge rst_ni) begin
      if (!rst_ni) begin
         tick_q <= 32'h0; n_q <= 4'h0; oacc_q <= '0; dacc_q <= '0;
         done_o <= 1'b0; obj_o <= irsb_pkg::RES_RESET; die_o <= 14'h0;
      end else if (ce_i) begin
         done_o <= 1'b0;
         if (soft_rst_i || !run_i) begin
            tick_q <= 32'h0; n_q <= 4'h0; oacc_q <= '0; dacc_q <= '0;
            if (soft_rst_i) begin
               obj_o <= irsb_pkg::RES_RESET;
               die_o <= 14'h0;
            end
         end else if (tick_q != 32'(SAMPLE_CYC - 1)) begin
            tick_q <= tick_q + 32'h1;
         end else begin
            tick_q <= 32'h0;
            if (n_q == 4'((1 << rate) - 1)) begin
               n_q <= 4'h0; oacc_q <= '0; dacc_q <= '0;
               done_o <= 1'b1;
               die_o <= davg[13:0];
               if (oavg > (OBJ_W+4)'(32767)) obj_o <= irsb_pkg::OBJ_POS_SAT;
               else if (oavg < -(OBJ_W+4)'(32768))
                  obj_o <= irsb_pkg::OBJ_NEG_SAT;
               else obj_o <= oavg[15:0];
            end else begin
               n_q <= n_q + 4'h1; oacc_q <= osum; dacc_q <= dsum;
            end
         end
      end
   end
   a_pdown_abort: assert property (@(posedge clk_i) disable iff (!rst_ni)
      ce_i && !run_i |=> tick_q == 32'h0 && n_q == 4'h0)
      else $error("conversion not aborted in power-down");
endmodule
`default_nettype wire

// >>> core/irsb_top.sv
// Register bank and slave addressing of an IR temperature sensor.
// Assumes bus pins resolved outside and a same-clock front end.
// Function
// - Slave address is 1000, high select bit, then four-state low select.
// - Select pins are sampled again at every bus transaction start.
// - Each transaction opens with seven address bits and a direction bit.
// - Write-only 8-bit pointer selects registers, loaded on every write.
// - Pointer holds zero after reset, selecting object voltage.
// - Pointers 00h, 01h, 02h, FEh, FFh map the five registers.
// - Object voltage is 16-bit signed, read-only, zero after reset.
// - Object voltage clips at 7FFFh and 8000h on overrange.
// - Die temperature sits in bits 15:2; bits 1:0 read zero.
// - Each finished conversion overwrites the die temperature.
// - Die temperature reads 0000h until the first conversion.
// - Startup settings give one conversion per second.
// - Ready pin is open-drain, active low, only pulls low.
// - Config bit 15 resets every register, then reads zero.
// - Bit 7 flags fresh results; bit 8 enables the ready pin.
// - Rate codes 000..100 give 4..0.25 per second, averaging 1..16.
`timescale 1ns/1ps
`default_nettype none
module irsb_top #(
   parameter int          OBJ_W      = 18,
   parameter int          SAMPLE_CYC = irsb_pkg::SAMPLE_CYC,
   parameter logic [15:0] MAKER_ID   = irsb_pkg::MAKER_ID_DEF,
   parameter logic [15:0] PART_ID    = irsb_pkg::PART_ID_DEF
) (
   // Clock, reset, enable
   input  wire logic             mclk_i,
   input  wire logic             resetn_i,
   input  wire logic             ce_i,
   // Serial bus
   input  wire logic             scl_i,
   input  wire logic             sda_i,
   output logic                  sda_o,
   output logic                  sda_oe_o,
   // Address select straps
   input  wire logic             addr_select_low_i,
   input  wire logic             addr_select_high_i,
   // Ready pin, open-drain
   output logic                  result_ready_n_o,
   output logic                  result_ready_n_oe_o,
   // Front-end samples
   input  wire logic [OBJ_W-1:0] obj_sample_i,
   input  wire logic [13:0]      die_sample_i
);
   irsb_if lk ();
   logic [1:0]  rst_pipe_q;
   logic        rst_n;
   logic [irsb_pkg::SY_W-1:0] s1_q, s2_q, s3_q;
   logic        scl_s, sda_s, start_det, stop_det, scl_fall;
   logic        ev_seen, rd_seen, cfg_wr, sw_rst, rdy_clr;
   logic        link_rst_n_q, pend_q, low_idle_q, low_start_q, high_q;
   logic [6:0]  addr_q;
   logic [1:0]  low_code;
   logic [7:0]  ptr_q;
   logic [2:0]  mode_q, rate_q;
   logic        en_q, rdy_q, conv_done;
   logic [15:0] obj_res, cfg_rd, mux_w, rd_word_q;
   logic [13:0] die_res;
   logic        rdy_oe_q, rdy_o_q;

   ////////////////////////////////////////////////////////////////////
   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_pipe_q <= 2'h0;
      end else begin
         rst_pipe_q <= {rst_pipe_q[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe_q[1];

   // Pins and link toggles pass two flops; third stage for edges
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else if (ce_i) begin
         s1_q <= {lk.rd_tgl, lk.ev_tgl, addr_select_high_i,
                  addr_select_low_i, sda_i, scl_i};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   assign scl_s     = s2_q[irsb_pkg::SY_SCL];
   assign sda_s     = s2_q[irsb_pkg::SY_SDA];
   assign start_det = scl_s && s3_q[irsb_pkg::SY_SCL] &&
                      s3_q[irsb_pkg::SY_SDA] && !sda_s;
   assign stop_det  = scl_s && s3_q[irsb_pkg::SY_SCL] &&
                      !s3_q[irsb_pkg::SY_SDA] && sda_s;
   assign scl_fall  = s3_q[irsb_pkg::SY_SCL] && !scl_s;
   assign ev_seen   = s2_q[irsb_pkg::SY_EV] ^ s3_q[irsb_pkg::SY_EV];
   assign rd_seen   = s2_q[irsb_pkg::SY_RD] ^ s3_q[irsb_pkg::SY_RD];

   ////////////////////////////////////////////////////////////////////
   // Four-state low select: ground, supply, data wire or clock wire.
   // Idle (both high), start (data low) and first clock low tell apart.
   always_comb begin
      if (!low_start_q && !low_idle_q) begin
         low_code = 2'h0;                  // Tied low
      end else if (!low_start_q) begin
         low_code = 2'h2;                  // Follows data
      end else if (s2_q[irsb_pkg::SY_LOW]) begin
         low_code = 2'h1;                  // Tied high
      end else begin
         low_code = 2'h3;                  // Follows clock
      end
   end

   // Frame tracking; the link runs only between first clock fall and
   // stop, so its state never outlives a frame
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         link_rst_n_q <= 1'b0;
         pend_q <= 1'b0;
         low_idle_q <= 1'b0;
         low_start_q <= 1'b0;
         high_q <= 1'b0;
         addr_q <= irsb_pkg::ADDR_RESET;
      end else if (ce_i) begin
         if (start_det) begin
            link_rst_n_q <= 1'b0;
            pend_q <= 1'b1;
            low_idle_q <= s3_q[irsb_pkg::SY_LOW];
            low_start_q <= s2_q[irsb_pkg::SY_LOW];
            high_q <= s2_q[irsb_pkg::SY_HIGH];
         end else if (stop_det) begin
            link_rst_n_q <= 1'b0;
            pend_q <= 1'b0;
         end else if (pend_q && scl_fall) begin
            link_rst_n_q <= 1'b1;
            pend_q <= 1'b0;
            addr_q <= {irsb_pkg::ADDR_PREFIX, high_q, low_code};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Decoded write events from the link
   assign cfg_wr = ev_seen && lk.ev_has_data &&
                   lk.ev_ptr == irsb_pkg::PTR_CFG;
   assign sw_rst = cfg_wr && lk.ev_data[irsb_pkg::CFG_RST_BIT];
   assign rdy_clr = cfg_wr || (rd_seen && (ptr_q == irsb_pkg::PTR_OBJ ||
                                           ptr_q == irsb_pkg::PTR_DIE));

   // Pointer: loaded by every write, cleared by software reset
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ptr_q <= irsb_pkg::PTR_RESET;
      end else if (ce_i) begin
         if (sw_rst) begin
            ptr_q <= irsb_pkg::PTR_RESET;
         end else if (ev_seen) begin
            ptr_q <= lk.ev_ptr;
         end
      end
   end

   // Configuration fields; writes to any other pointer change nothing
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= irsb_pkg::MODE_RESET;
         rate_q <= irsb_pkg::RATE_RESET;
         en_q <= 1'b0;
      end else if (ce_i) begin
         if (sw_rst) begin
            mode_q <= irsb_pkg::MODE_RESET;
            rate_q <= irsb_pkg::RATE_RESET;
            en_q <= 1'b0;
         end else if (cfg_wr) begin
            mode_q <= lk.ev_data[irsb_pkg::CFG_MODE_LSB +: 3];
            rate_q <= lk.ev_data[irsb_pkg::CFG_RATE_LSB +: 3];
            en_q <= lk.ev_data[irsb_pkg::CFG_EN_BIT];
         end
      end
   end

   // Ready flag: a finishing conversion beats a same-cycle clear; a software reset beats both
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdy_q <= 1'b0;
      end else if (ce_i) begin
         if (sw_rst) begin
            rdy_q <= 1'b0;
         end else if (conv_done) begin
            rdy_q <= 1'b1;
         end else if (rdy_clr) begin
            rdy_q <= 1'b0;
         end
      end
   end

   irsb_conv #(
      .OBJ_W      (OBJ_W),
      .SAMPLE_CYC (SAMPLE_CYC)
   ) u_conv (
      .clk_i      (mclk_i),
      .rst_ni     (rst_n),
      .ce_i       (ce_i),
      .soft_rst_i (sw_rst),
      .run_i      (mode_q == irsb_pkg::MODE_CONT),
      .rate_i     (rate_q),
      .obj_i      (obj_sample_i),
      .die_i      (die_sample_i),
      .done_o     (conv_done),
      .obj_o      (obj_res),
      .die_o      (die_res)
   );

   ////////////////////////////////////////////////////////////////////
   // Read view; the reset bit and unused bits always read zero
   assign cfg_rd = {1'b0, mode_q, rate_q, en_q, rdy_q, 7'h00};

   always_comb begin
      unique case (ptr_q)
         irsb_pkg::PTR_OBJ:   mux_w = obj_res;
         irsb_pkg::PTR_DIE:   mux_w = {die_res, 2'h0};
         irsb_pkg::PTR_CFG:   mux_w = cfg_rd;
         irsb_pkg::PTR_MAKER: mux_w = MAKER_ID;
         irsb_pkg::PTR_PART:  mux_w = PART_ID;
         default:             mux_w = 16'h0000;
      endcase
   end

   // Snapshot only while the link is held; it then stays still for
   // the whole frame, which makes the word safe to cross
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         rd_word_q <= irsb_pkg::RES_RESET;
      end else if (ce_i && !link_rst_n_q) begin
         rd_word_q <= mux_w;
      end
   end

   assign lk.rd_word    = rd_word_q;
   assign lk.slave_addr = addr_q;
   assign lk.link_rst_n = link_rst_n_q;
   assign lk.core_rst_n = rst_n;

   // Ready pin pulls low only; never drives high
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdy_oe_q <= 1'b0;
         rdy_o_q <= 1'b0;
      end else if (ce_i) begin
         rdy_oe_q <= en_q && rdy_q;
         rdy_o_q <= 1'b0;
      end
   end
   assign result_ready_n_oe_o = rdy_oe_q;
   assign result_ready_n_o    = rdy_o_q;

   irsb_link u_link (
      .scl_i    (scl_i),
      .sda_i    (sda_i),
      .sda_o    (sda_o),
      .sda_oe_o (sda_oe_o),
      .lk       (lk.link)
   );

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n);

   sequence s_reset_write;
      ce_i && cfg_wr && lk.ev_data[irsb_pkg::CFG_RST_BIT];
   endsequence
   sequence s_back_to_reset;
      cfg_rd == irsb_pkg::CFG_RESET && ptr_q == irsb_pkg::PTR_RESET &&
      die_res == 14'h0 && obj_res == irsb_pkg::RES_RESET;
   endsequence

   a_addr_prefix: assert property (
      ce_i && pend_q && scl_fall && !start_det && !stop_det |=>
      addr_q[6:3] == irsb_pkg::ADDR_PREFIX && addr_q[2] == $past(high_q))
      else $error("slave address not formed from prefix and pins");
   a_ptr_load: assert property (
      ce_i && ev_seen && !sw_rst |=> ptr_q == $past(lk.ev_ptr))
      else $error("pointer not loaded by write");
   a_soft_reset: assert property (
      s_reset_write |=> s_back_to_reset)
      else $error("software reset left a register changed");
   a_ro_ignored: assert property (
      ce_i && ev_seen && lk.ev_has_data &&
      lk.ev_ptr != irsb_pkg::PTR_CFG |=> $stable(cfg_rd[15:8]))
      else $error("write to read-only register had effect");
   a_ready_set: assert property (
      ce_i && conv_done && !sw_rst |=> rdy_q ##1 (!ce_i || rdy_oe_q == en_q))
      else $error("ready flag or pin missed a result");
   a_ready_clear: assert property (
      ce_i && rdy_clr && !conv_done && !sw_rst |=> !rdy_q)
      else $error("ready flag not cleared");
   a_pin_low_only: assert property (
      result_ready_n_o == 1'b0 and (rdy_oe_q |-> $past(en_q)))
      else $error("ready pin drives high or ignores enable");
   a_die_low_zero: assert property (
      ptr_q == irsb_pkg::PTR_DIE |-> mux_w[1:0] == 2'h0)
      else $error("die register low bits not zero");
   a_snap_frozen: assert property (
      link_rst_n_q && $past(link_rst_n_q) |-> $stable(rd_word_q))
      else $error("read word moved during a frame");
endmodule
`default_nettype wire

// >>> test/irsb_master.sv
// Bus master model: push-pull clock, open-drain data.
// Assumes a pull-up on data; the clock stands high between frames.
`timescale 1ns/1ps
`default_nettype none
module irsb_master (
   // Bus lines
   output logic      scl_o,
   output logic      sda_o,
   input  wire logic sda_i
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   ////////////////////////////////////////
   // Frame edges: data moves while clock is high
   task automatic start();
      #40 sda_o = 1'b1;
      #40 scl_o = 1'b1;
      #80 sda_o = 1'b0;
      #80 scl_o = 1'b0;
   endtask
   task automatic stop();
      #40 sda_o = 1'b0;
      #40 scl_o = 1'b1;
      #80 sda_o = 1'b1;
      #80;
   endtask
   // Nine bits MSB first; a 1 releases the line so the slave can pull
   task automatic bits(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--) begin
         #40 sda_o = d[i];
         #40 scl_o = 1'b1;
         q[i] = sda_i;
         #80 scl_o = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// >>> test/testbench.sv
// Bench of the sensor register bank: bus frames and result checks.
// Assumes the master model and pull-ups on both open-drain lines.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        mclk_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic        ce_i = 1'b1;
   logic [1:0]  sel_lo = 2'h0;
   logic        sel_hi = 1'b0;
   logic [17:0] obj_s = 18'h00000;
   logic [13:0] die_s = 14'h0000;
   logic [6:0]  adr = 7'h40;
   logic [8:0]  q;
   logic [15:0] v;
   int          n_errors = 0;
   int          compares = 0;
   wire logic   scl, m_sda, sda_d, sda_oe, rdy_d, rdy_oe, sda, lo_pin;
   ////////////////////////////////////////
   // Wired lines resolve against pull-ups
   assign sda = m_sda & ~sda_oe;
   assign lo_pin = sel_lo == 2'h2 ? sda : sel_lo == 2'h3 ? scl : sel_lo[0];
   always #2.5 mclk_i = ~mclk_i;
   irsb_master m (.scl_o(scl), .sda_o(m_sda), .sda_i(sda));
   irsb_top #(.SAMPLE_CYC(2000)) uut (.mclk_i, .resetn_i, .ce_i,
      .scl_i(scl), .sda_i(sda), .sda_o(sda_d), .sda_oe_o(sda_oe),
      .addr_select_low_i(lo_pin), .addr_select_high_i(sel_hi),
      .result_ready_n_o(rdy_d), .result_ready_n_oe_o(rdy_oe),
      .obj_sample_i(obj_s), .die_sample_i(die_s));
   task automatic check(input string nm, input logic [15:0] got, exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic end_of_test();
      if (n_errors == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Pointer write, with an optional data word
   task automatic wr(input logic [7:0] p, input logic [15:0] d, input logic f);
      m.start();
      m.bits({adr, 2'h1}, q);
      check("ack", {15'h0, q[0]}, 16'h0);
      m.bits({p, 1'b1}, q);
      if (f) begin
         m.bits({d[15:8], 1'b1}, q);
         m.bits({d[7:0], 1'b1}, q);
      end
      m.stop();
   endtask
   // Word read, high byte first, master acks then nacks
   task automatic rd(input logic [15:0] e);
      m.start();
      m.bits({adr, 2'h3}, q);
      m.bits(9'h1FE, q);
      v[15:8] = q[8:1];
      m.bits(9'h1FF, q);
      v[7:0] = q[8:1];
      m.stop();
      check("read", v, e);
      check("sda_o", {15'h0, sda_d}, 16'h0);
   endtask
   // Power down first so no stale samples enter the average
   task automatic convert(input logic [17:0] o, input logic [13:0] d);
      int i;
      wr(irsb_pkg::PTR_CFG, 16'h0000, 1'b1);
      check("ready", {15'h0, rdy_oe}, 16'h0);
      @(posedge mclk_i);
      obj_s <= o;
      die_s <= d;
      wr(irsb_pkg::PTR_CFG, 16'h7100, 1'b1);
      for (i = 0; i < 4000 && rdy_oe !== 1'b1; i++)
         @(posedge mclk_i);
      check("ready", {14'h0, rdy_oe, rdy_d}, 16'h2);
      if (i == 4000)
         end_of_test();
   endtask
   initial begin
      #450000;
      n_errors++;
      end_of_test();
   end
   initial begin
      repeat (6) @(posedge mclk_i);
      resetn_i <= 1'b1;
      repeat (8) @(posedge mclk_i);
      rd(16'h0000);
      wr(irsb_pkg::PTR_DIE, 16'h0, 1'b0);
      rd(16'h0000);
      wr(irsb_pkg::PTR_CFG, 16'h0, 1'b0);
      rd(16'h7400);
      wr(irsb_pkg::PTR_MAKER, 16'h1234, 1'b1);
      rd(irsb_pkg::MAKER_ID_DEF);
      wr(irsb_pkg::PTR_PART, 16'h0, 1'b0);
      for (int s = 0; s < 8; s++) begin
         @(posedge mclk_i);
         {sel_hi, sel_lo} <= 3'(s);
         adr = 7'h40 | 7'(s);
         repeat (8) @(posedge mclk_i);
         rd(irsb_pkg::PART_ID_DEF);
      end
      adr = 7'h46;
      m.start();
      m.bits({adr, 2'h3}, q);
      m.stop();
      check("nack", {15'h0, q[0]}, 16'h1);
      adr = 7'h47;
      convert(18'h1FFFF, 14'h3F9C);
      rd(16'h7180);
      wr(irsb_pkg::PTR_OBJ, 16'h0, 1'b0);
      rd(16'h7FFF);
      wr(irsb_pkg::PTR_DIE, 16'h0, 1'b0);
      rd(16'hFE70);
      convert(18'h20000, 14'h0001);
      wr(irsb_pkg::PTR_OBJ, 16'h5555, 1'b1);
      rd(16'h8000);
      wr(irsb_pkg::PTR_DIE, 16'h0, 1'b0);
      rd(16'h0004);
      wr(irsb_pkg::PTR_CFG, 16'h8000, 1'b1);
      rd(16'h0000);
      wr(irsb_pkg::PTR_CFG, 16'h0, 1'b0);
      rd(16'h7400);
      end_of_test();
   end
endmodule
`default_nettype wire
